// >>> design/fps_sequencer.sv
// fault protection sequencer for one regulator rail: qualifies overcurrent and
// overvoltage, masks them around voltage transitions, forces the gate drives.
// assumes all inputs synchronous to i_ref_clk; sense values in millivolts.
`timescale 1ns/1ns
`include "fps_consts.svh"

module fps_sequencer #(
  parameter int unsigned NPH         = 3,
  parameter int unsigned OC_QUAL_CYC = `FPS_OC_QUAL_CYC,
  parameter int unsigned REEN_CYC    = `FPS_REEN_CYC,
  parameter int unsigned OV_QUAL_CYC = `FPS_OV_QUAL_CYC,
  parameter int unsigned CUR_W       = 12
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_rail_en,
  input  wire logic               i_transition_alert,
  input  wire fps_pkg::fps_sense_s i_sense,
  input  wire logic [CUR_W-1:0]   i_current_monitor,
  input  wire logic [CUR_W-1:0]   i_first_setting_pin_oc,
  input  wire logic [NPH-1:0]     i_pwm_high,
  input  wire logic [NPH-1:0]     i_pwm_low,
  output logic [NPH-1:0]          o_high_side_gate,
  output logic [NPH-1:0]          o_low_side_gate,
  output fps_pkg::fps_fault_s     o_fault,
  output logic                    o_mask_active
);

  localparam int CW = `FPS_CNT_W;

  logic               alert_q;
  logic               mask_q;
  logic [CW-1:0]      mask_cnt_q;
  logic [1:0]         cond;
  logic [1:0]         hit;
  logic [CW-1:0]      lim [2];
  logic [CW-1:0]      cnt_q [2];
  logic signed [16:0] cmd_mv;
  logic signed [16:0] ov_ref_mv;
  logic signed [16:0] sense_ext;
  logic               oc_q;
  logic               oc_d;
  fps_pkg::fps_ov_e   state_q;
  fps_pkg::fps_ov_e   state_d;
  logic [NPH-1:0]     high_d;
  logic [NPH-1:0]     low_d;

  // masking window: opens on the alert's rising edge, closes after REEN_CYC
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= i_transition_alert;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mask_q     <= 1'b0;
      mask_cnt_q <= '0;
    end else if (i_transition_alert && !alert_q) begin
      mask_q     <= 1'b1;
      mask_cnt_q <= '0;
    end else if (mask_q) begin
      if (mask_cnt_q == CW'(REEN_CYC - 1)) begin
        mask_q <= 1'b0;
      end else begin
        mask_cnt_q <= mask_cnt_q + 1'b1;
      end
    end
  end

  // a new alert inside the window restarts it, so the window is always
  // measured from the most recent transition start
  assign o_mask_active = mask_q;

  // commanded level in mV; code zero means the rail is commanded off
  always_comb begin
    cmd_mv = 17'sh00000;
    if (i_sense.commanded_voltage_code != 8'h00) begin
      cmd_mv = 17'(`FPS_CODE_BASE_MV + `FPS_CODE_STEP_MV * int'(i_sense.commanded_voltage_code));
    end
  end

  always_comb begin
    if (cmd_mv > `FPS_OV_FLOOR_MV) begin
      ov_ref_mv = cmd_mv + `FPS_OV_MARGIN_MV;
    end else begin
      ov_ref_mv = `FPS_OV_FLOOR_MV + `FPS_OV_MARGIN_MV;
    end
  end

  assign sense_ext = 17'(i_sense.output_sense);

  // raw conditions; the threshold input is the decoded setting pin value
  assign cond[0] = (i_current_monitor > i_first_setting_pin_oc) && !mask_q;
  assign cond[1] = (sense_ext > ov_ref_mv) && !mask_q;
  assign lim[0]  = CW'(OC_QUAL_CYC);
  assign lim[1]  = CW'(OV_QUAL_CYC);

  // qualification timers: count consecutive cycles, any dropout restarts
  for (genvar gi = 0; gi < 2; gi++) begin : g_qual
    always_ff @(posedge i_ref_clk) begin
      if (i_rst || !i_rail_en || !cond[gi]) begin
        cnt_q[gi] <= '0;
      end else if (cnt_q[gi] != lim[gi] - 1'b1) begin
        cnt_q[gi] <= cnt_q[gi] + 1'b1;
      end
    end
    assign hit[gi] = cond[gi] && (cnt_q[gi] == lim[gi] - 1'b1);
  end

  assign oc_d = oc_q || hit[0];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_rail_en) begin
      oc_q <= 1'b0;
    end else begin
      oc_q <= oc_d;
    end
  end

  // overvoltage sequence: clamp, and bounce into the negative trip and back
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fps_pkg::OV_IDLE: begin
        if (hit[1]) begin
          state_d = fps_pkg::OV_CLAMP;
        end
      end
      fps_pkg::OV_CLAMP: begin
        if (i_sense.output_sense < `FPS_NV_TRIP_MV) begin
          state_d = fps_pkg::OV_NEG;
        end
      end
      fps_pkg::OV_NEG: begin
        if (i_sense.output_sense > `FPS_NV_CLEAR_MV) begin
          state_d = fps_pkg::OV_CLAMP;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_rail_en) begin
      state_q <= fps_pkg::OV_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // gate overrides follow the next state so the clamp lands with the latch;
  // rail disable hands the gates back to the modulator on the same edge
  always_comb begin
    high_d = i_pwm_high;
    low_d  = i_pwm_low;
    unique case (i_rail_en ? state_d : fps_pkg::OV_IDLE)
      fps_pkg::OV_IDLE: begin
        high_d = i_pwm_high;
        low_d  = i_pwm_low;
      end
      fps_pkg::OV_CLAMP: begin
        high_d = '0;
        low_d  = '1;
      end
      fps_pkg::OV_NEG: begin
        high_d = '0;
        low_d  = '0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_high_side_gate <= '0;
      o_low_side_gate  <= '0;
    end else begin
      o_high_side_gate <= high_d;
      o_low_side_gate  <= low_d;
    end
  end

  // fault flags mirror the latches on the same edge
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_rail_en) begin
      o_fault <= '0;
    end else begin
      o_fault.overcurrent_trip      <= oc_d;
      o_fault.overvoltage_trip      <= (state_d != fps_pkg::OV_IDLE);
      o_fault.negative_voltage_trip <= (state_d == fps_pkg::OV_NEG);
    end
  end

  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_oc_qualified;
    $rose(o_fault.overcurrent_trip) && $past(i_rail_en);
  endsequence

  sequence s_neg_dip;
    (state_q == fps_pkg::OV_CLAMP) && (i_sense.output_sense < `FPS_NV_TRIP_MV) && i_rail_en;
  endsequence

  sequence s_neg_recover;
    (state_q == fps_pkg::OV_NEG) && (i_sense.output_sense > `FPS_NV_CLEAR_MV) && i_rail_en;
  endsequence

  a_oc_qual_time: assert property (
    s_oc_qualified |-> $past(cnt_q[0]) == lim[0] - 1'b1 && $past(cond[0]))
    else $error("overcurrent latched before its qualification time");

  a_oc_uses_setting: assert property (
    (cnt_q[0] != '0) |-> $past(i_current_monitor > i_first_setting_pin_oc))
    else $error("overcurrent timer ran without exceeding the setting threshold");

  a_mask_blocks_det: assert property (
    mask_q |=> (cnt_q[0] == '0) && (cnt_q[1] == '0))
    else $error("detection timer ran inside the masking window");

  a_mask_opens_now: assert property (
    (i_transition_alert && !alert_q) |=> mask_q && (mask_cnt_q == '0))
    else $error("masking window did not open on the alert edge");

  a_mask_closes_on: assert property (
    (mask_q && mask_cnt_q == CW'(REEN_CYC - 1) && !(i_transition_alert && !alert_q)) |=> !mask_q)
    else $error("masking window did not close after its length");

  a_ov_ref_high: assert property (
    (cnt_q[1] != '0 && $past(cmd_mv) > `FPS_OV_FLOOR_MV) |->
      $past(sense_ext) > $past(cmd_mv) + `FPS_OV_MARGIN_MV)
    else $error("overvoltage timer ran below command plus margin");

  a_ov_ref_floor: assert property (
    (cnt_q[1] != '0 && $past(cmd_mv) <= `FPS_OV_FLOOR_MV) |->
      $past(sense_ext) > `FPS_OV_FLOOR_MV + `FPS_OV_MARGIN_MV)
    else $error("overvoltage timer ran below the fixed floor reference");

  a_ov_qual_time: assert property (
    $rose(o_fault.overvoltage_trip) |-> $past(cnt_q[1]) == CW'(OV_QUAL_CYC - 1))
    else $error("overvoltage latched before its qualification time");

  a_ov_gate_clamp: assert property (
    (state_q == fps_pkg::OV_CLAMP) |-> (o_high_side_gate == '0) && (o_low_side_gate == '1))
    else $error("gates not clamped during overvoltage");

  a_nv_gates_off: assert property (
    s_neg_dip |=> (o_high_side_gate == '0) && (o_low_side_gate == '0) && o_fault.negative_voltage_trip)
    else $error("negative trip did not release all gates");

  a_nv_return_ov: assert property (
    s_neg_recover |=> (state_q == fps_pkg::OV_CLAMP) && (o_low_side_gate == '1))
    else $error("negative trip did not return to the clamp");

  a_nv_needs_ov: assert property (
    o_fault.negative_voltage_trip |-> o_fault.overvoltage_trip && $past(state_q) != fps_pkg::OV_IDLE)
    else $error("negative trip without a latched overvoltage");

  a_fault_hold: assert property (
    (o_fault.overcurrent_trip && i_rail_en) |=> o_fault.overcurrent_trip)
    else $error("overcurrent flag dropped without re-enable");

  a_qual_restart: assert property (
    (!cond[1] ##1 (cond[1] && i_rail_en)) |=> (cnt_q[1] == 16'h0001) || $rose(o_fault.overvoltage_trip))
    else $error("overvoltage timer did not restart after a dropout");

  a_rail_clears: assert property (
    !i_rail_en |=> (o_fault == '0) && (cnt_q[0] == '0) && (cnt_q[1] == '0))
    else $error("rail disable left a fault or timer standing");

  a_ov_latch_hold: assert property (
    (o_fault.overvoltage_trip && i_rail_en) |=> o_fault.overvoltage_trip)
    else $error("overvoltage flag dropped without re-enable");

  a_nv_idle_quiet: assert property (
    ((state_q == fps_pkg::OV_IDLE) && (i_sense.output_sense < `FPS_NV_TRIP_MV)) |=> !o_fault.negative_voltage_trip)
    else $error("negative trip raised from the idle state");

  a_pwm_pass: assert property (
    (state_d == fps_pkg::OV_IDLE) |=>
      (o_high_side_gate == $past(i_pwm_high)) && (o_low_side_gate == $past(i_pwm_low)))
    else $error("gates did not follow the modulator outside a fault");

endmodule // fps_sequencer

// >>> inc/fps_consts.svh
// timing counts, trip levels and voltage code scaling for the fault sequencer
// assumes a 125 MHz reference clock and millivolt-scaled sense values
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH
`define FPS_CLK_MHZ       125
`define FPS_OC_QUAL_NS    40000
`define FPS_REEN_NS       46000
`define FPS_OV_QUAL_NS    500
// least times, rounded up to whole cycles
`define FPS_OC_QUAL_CYC   ((`FPS_OC_QUAL_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_REEN_CYC      ((`FPS_REEN_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_OV_QUAL_CYC   ((`FPS_OV_QUAL_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_OV_MARGIN_MV  17'sh0015e
`define FPS_OV_FLOOR_MV   17'sh003e8
`define FPS_NV_TRIP_MV    16'shffba
`define FPS_NV_CLEAR_MV   16'sh0000
`define FPS_CODE_BASE_MV  245
`define FPS_CODE_STEP_MV  5
`define FPS_CNT_W         16
`endif

// >>> inc/fps_pkg.sv
// types shared by the fault protection sequencer
// constants live in fps_consts.svh
package fps_pkg;
  typedef enum logic [1:0] {
    OV_IDLE,
    OV_CLAMP,
    OV_NEG
  } fps_ov_e;

  typedef struct packed {
    logic signed [15:0] output_sense;
    logic [7:0]         commanded_voltage_code;
  } fps_sense_s;

  typedef struct packed {
    logic overcurrent_trip;
    logic overvoltage_trip;
    logic negative_voltage_trip;
  } fps_fault_s;
endpackage

// >>> verification/fps_sequencer_tb.sv
// self-checking bench for the fault protection sequencer with shortened timer counts
// assumes sense values in millivolts and command mV = 245 + 5 * code
`timescale 1ns/1ns
module fps_sequencer_tb;
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
    logic [2:0] flt;
    logic       msk;
  } fps_note_s;
  logic                i_ref_clk = 1'b0;
  logic                rst       = 1'b1;
  logic                rail_en   = 1'b0;
  logic                alert     = 1'b0;
  fps_pkg::fps_sense_s sense     = '0;
  logic [11:0]         cur       = '0;
  logic [11:0]         thr       = '0;
  logic [2:0]          pat       = '0;
  logic [2:0]          p         = '0;
  logic [11:0]         t;
  logic [2:0]          pwm_h;
  logic [2:0]          pwm_l;
  logic [2:0]          hi;
  logic [2:0]          lo;
  fps_pkg::fps_fault_s flt;
  logic                msk;
  logic                shoot;
  fps_note_s           notes[$];
  int                  mismatches   = 0;
  int                  total_checks = 0;
  int                  refs[2]      = '{1350, 1595};
  logic [7:0]          codes[2]     = '{8'h64, 8'hc8};

  always #4 i_ref_clk = ~i_ref_clk;

  fps_sequencer #(.OC_QUAL_CYC(20), .REEN_CYC(30), .OV_QUAL_CYC(5)) fps_sequencer_i (
    .i_ref_clk              (i_ref_clk),
    .i_rst                  (rst),
    .i_rail_en              (rail_en),
    .i_transition_alert     (alert),
    .i_sense                (sense),
    .i_current_monitor      (cur),
    .i_first_setting_pin_oc (thr),
    .i_pwm_high             (pwm_h),
    .i_pwm_low              (pwm_l),
    .o_high_side_gate       (hi),
    .o_low_side_gate        (lo),
    .o_fault                (flt),
    .o_mask_active          (msk)
  );

  fps_stage_model fps_stage_model_i (
    .i_pattern        (pat),
    .i_high_side_gate (hi),
    .i_low_side_gate  (lo),
    .o_pwm_high       (pwm_h),
    .o_pwm_low        (pwm_l),
    .o_shoot_through  (shoot)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  task automatic note(input logic [2:0] h, input logic [2:0] l, input logic [2:0] f, input logic m);
    notes.push_back('{h, l, f, m});
  endtask

  task automatic chk_out(input fps_note_s n);
    total_checks++;
    if ({hi, lo, flt, msk, shoot} !== {n, 1'b0}) begin
      mismatches++;
      $display("BAD %0t outputs %h expected %h", $time, {hi, lo, flt, msk, shoot}, {n, 1'b0});
    end
  endtask

  // outputs have settled by the falling edge after the edge that recorded the note
  always @(negedge i_ref_clk) begin
    if (notes.size() > 0) chk_out(notes.pop_front());
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic clear_rail();
    rail_en <= 1'b0;
    sense   <= '0;
    cur     <= t;
    tick(2);
    note(p, ~p, 3'h0, 1'b0);
    rail_en <= 1'b1;
  endtask

  initial begin
    void'($urandom(32'h42753a38));
    tick(4);
    note(3'h0, 3'h0, 3'h0, 1'b0);
    tick(1);
    rst     <= 1'b0;
    rail_en <= 1'b1;
    repeat (4) begin
      p = 3'($urandom());
      pat <= p;
      tick(1);
      note(p, ~p, 3'h0, 1'b0);
    end
    t = 12'($urandom_range(4000, 100));
    thr <= t;
    cur <= t;
    tick(25);
    note(p, ~p, 3'h0, 1'b0);
    cur <= t + 12'h001;
    tick(19);
    note(p, ~p, 3'h0, 1'b0);
    cur <= t;
    tick(1);
    cur <= t + 12'h001;
    tick(19);
    note(p, ~p, 3'h0, 1'b0);
    tick(1);
    note(p, ~p, 3'h4, 1'b0);
    clear_rail();
    alert <= 1'b1;
    cur   <= t + 12'h001;
    sense <= '{16'sd1400, 8'h64};
    tick(25);
    note(p, ~p, 3'h0, 1'b1);
    alert <= 1'b0;
    tick(5);
    note(p, ~p, 3'h0, 1'b1);
    tick(1);
    note(p, ~p, 3'h0, 1'b0);
    tick(29);
    note(3'h0, 3'h7, 3'h6, 1'b0);
    clear_rail();
    for (int i = 0; i < 2; i++) begin
      sense <= '{-16'sd100, codes[i]};
      tick(3);
      note(p, ~p, 3'h0, 1'b0);
      sense <= '{16'(refs[i]), codes[i]};
      tick(10);
      note(p, ~p, 3'h0, 1'b0);
      sense <= '{16'(refs[i] + 1), codes[i]};
      tick(4);
      note(p, ~p, 3'h0, 1'b0);
      tick(1);
      note(3'h0, 3'h7, 3'h2, 1'b0);
      sense <= '{-16'sd71, codes[i]};
      tick(1);
      note(3'h0, 3'h0, 3'h3, 1'b0);
      sense <= '{16'sd0, codes[i]};
      tick(1);
      note(3'h0, 3'h0, 3'h3, 1'b0);
      sense <= '{16'sd1, codes[i]};
      tick(1);
      note(3'h0, 3'h7, 3'h2, 1'b0);
      clear_rail();
    end
    tick(2);
    complete_run();
  end

  // the whole sequence needs about 200 cycles
  initial begin
    #8000;
    mismatches++;
    complete_run();
  end
endmodule // fps_sequencer_tb

// >>> verification/fps_stage_model.sv
// far-side model: phase gate drivers fed by the modulator, plus a shoot-through detector
// assumes the testbench supplies the modulator's per-phase pattern
`timescale 1ns/1ns
module fps_stage_model (
  input  wire logic [2:0] i_pattern,
  input  wire logic [2:0] i_high_side_gate,
  input  wire logic [2:0] i_low_side_gate,
  output logic [2:0]      o_pwm_high,
  output logic [2:0]      o_pwm_low,
  output logic            o_shoot_through
);
  // complementary demands, so a phase with both gates on can only come from the sequencer
  assign o_pwm_high = i_pattern;
  assign o_pwm_low  = ~i_pattern;
  assign o_shoot_through = |(i_high_side_gate & i_low_side_gate);
endmodule // fps_stage_model
